// ===== rtl/lds_host.sv
// host end: divides its clock to drive the serial clock, data and strobe
`timescale 1ns/100ps
`include "lds_cfg.svh"
module lds_host
  import lds_pkg::*;
#(
  parameter int HALF_PERIOD = `LDS_HALF_PERIOD,
  parameter int STROBE_GAP  = `LDS_STROBE_GAP
)(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  input  wire logic        start_in,
  input  wire logic        alarm_in,
  input  wire logic [16:0] word_in,
  lds_link_if.host         link,
  output logic             ready_out,
  output logic             done_out
);

  lds_host_state_t h_r;
  lds_host_state_t h_nxt;
  logic            tick_end;

  assign tick_end = (h_r.tick == 8'(HALF_PERIOD - 1));

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    h_nxt      = h_r;
    h_nxt.done = 1'b0;
    h_nxt.tick = tick_end ? 8'h00 : h_r.tick + 8'h01;
    unique case (h_r.st)
      LDS_IDLE: begin
        h_nxt.tick = 8'h00;
        if (start_in) begin
          h_nxt.st     = LDS_SETUP;
          h_nxt.strobe = 1'b0;
          if (alarm_in) begin
            // three bytes: seven pad bits lead, the 17-bit word ends it
            h_nxt.word      = {7'h00, word_in};
            h_nxt.bits_left = `LDS_FRAME_ALARM;
          end else begin
            h_nxt.word      = {word_in[15:0], 8'h00};
            h_nxt.bits_left = `LDS_FRAME_NORM;
          end
        end
      end
      LDS_SETUP: begin
        if (tick_end) begin
          h_nxt.st = LDS_SHIFT;
        end
      end
      LDS_SHIFT: begin
        if (tick_end) begin
          if (!h_r.sclk) begin
            h_nxt.sclk = 1'b1;
          end else begin
            h_nxt.sclk      = 1'b0;
            h_nxt.word      = {h_r.word[22:0], 1'b0};
            h_nxt.bits_left = h_r.bits_left - 5'h01;
            if (h_r.bits_left == 5'h01) begin
              h_nxt.st = LDS_HOLD;
            end
          end
        end
      end
      LDS_HOLD: begin
        if (tick_end) begin
          if (!h_r.strobe) begin
            h_nxt.strobe = 1'b1;
            h_nxt.tick   = 8'h00;
          end else if (h_r.tick == 8'h00) begin
            h_nxt.st = LDS_HOLD;
          end
        end
        if (h_r.strobe && h_r.tick == 8'(STROBE_GAP - 1)) begin
          h_nxt.st   = LDS_IDLE;
          h_nxt.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      h_r        <= '0;
      h_r.st     <= LDS_IDLE;
      h_r.strobe <= 1'b1;
    end else if (ce_in) begin
      h_r <= h_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.sclk   = h_r.sclk;
  assign link.sdata  = h_r.word[23];
  assign link.strobe = h_r.strobe;
  assign ready_out   = (h_r.st == LDS_IDLE);
  assign done_out    = h_r.done;

endmodule : lds_host

// ===== rtl/lds_cfg.svh
// constants for the loop converter serial code loader
`ifndef LDS_CFG_SVH
`define LDS_CFG_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define LDS_NORM_BITS    16
`define LDS_ALARM_BITS   17
`define LDS_CNT_BITS     5
`define LDS_ALARM_MIN    5'h11
`define LDS_FRAME_NORM   5'h10
`define LDS_FRAME_ALARM  5'h18
`define LDS_ZERO_LEVEL   17'h04000
`define LDS_CODE_RST     17'h00000

// ----------------------------------------------------------------
// host timing, in host clock cycles
// ----------------------------------------------------------------
`define LDS_HALF_PERIOD  4
`define LDS_STROBE_GAP   4

`endif

// ===== rtl/lds_pkg.sv
// types shared by both ends of the loop converter serial link
package lds_pkg;

  typedef struct packed {
    logic [16:0] shift;
    logic [4:0]  cnt_bin;
    logic [4:0]  cnt_gray;
  } lds_link_state_t;

  typedef struct packed {
    logic        stb_s1;
    logic        stb_s2;
    logic        stb_d;
    logic [4:0]  gray_s1;
    logic [4:0]  gray_s2;
    logic [4:0]  cnt_base;
    logic [16:0] code;
    logic        alarm;
    logic [16:0] level;
    logic        mod_en;
    logic        load;
  } lds_dev_state_t;

  typedef enum logic [3:0] {
    LDS_IDLE  = 4'b0001,
    LDS_SETUP = 4'b0010,
    LDS_SHIFT = 4'b0100,
    LDS_HOLD  = 4'b1000
  } lds_host_st_t;

  typedef struct packed {
    lds_host_st_t st;
    logic [23:0]  word;
    logic [4:0]   bits_left;
    logic [7:0]   tick;
    logic         sclk;
    logic         strobe;
    logic         done;
  } lds_host_state_t;

endpackage : lds_pkg

// ===== rtl/lds_link_if.sv
// three-wire link between the host end and the converter end
`timescale 1ns/100ps
interface lds_link_if;
  logic sclk;
  logic sdata;
  logic strobe;

  modport dev  (input  sclk, input  sdata, input  strobe);
  modport host (output sclk, output sdata, output strobe);
endinterface : lds_link_if

// ===== rtl/lds_dev.sv
// converter end: serial shift on the link clock, latch and coding on the modulator clock
// How it works
// - normal: 16-bit unsigned, zero is 4 mA
// - alarm: 17-bit unsigned over 0..32 mA
// - clock count 0-16 mod 32 means normal
// - clock count 17-31 mod 32 means alarm
// - normal step is 16 mA over 65536
// - alarm step equals the normal step
// - normal checkpoints 8, 12, 16 mA
// - alarm checkpoints 3.5, 20, 24 mA
// - host keeps alarm codes within 3.5-24 mA; lds_host sends word_in as given, unclamped
// - shift on clock rise, load on strobe rise
// - host: strobe low, upper then lower byte
// - host: data valid at clock rise
// - host: three bytes select alarm mode
// - most significant bit first
// - alarm keeps only last 17 bits
// - reset stops modulator, clears latch
`timescale 1ns/100ps
`include "lds_cfg.svh"
module lds_dev
  import lds_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  lds_link_if.dev          link,
  output logic [16:0]      code_out,
  output logic             alarm_out,
  output logic [16:0]      level_out,
  output logic             mod_en_out,
  output logic             osc_run_out,
  output logic             load_out
);

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  // the link clock only runs inside frames, so this side never clears
  // its own counter; the modulator side differences captured values.
  // reset acts without link clock edges; its release is quasi-static
  // because the host holds the link clock idle long after reset
  lds_link_state_t lk_r;
  lds_link_state_t lk_nxt;

  always_comb begin
    lk_nxt          = lk_r;
    // newest bit enters at the bottom, so the last 17 remain
    lk_nxt.shift    = {lk_r.shift[15:0], link.sdata};
    lk_nxt.cnt_bin  = lk_r.cnt_bin + 5'h01;
    lk_nxt.cnt_gray = lk_nxt.cnt_bin ^ {1'b0, lk_nxt.cnt_bin[4:1]};
  end

  always_ff @(posedge link.sclk or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ----------------------------------------------------------------
  // modulator clock domain
  // ----------------------------------------------------------------
  lds_dev_state_t dv_r;
  lds_dev_state_t dv_nxt;
  logic [4:0]     cnt_now;
  logic [4:0]     cnt_seen;
  logic           stb_rise;

  function automatic logic [4:0] gray_to_bin(input logic [4:0] g);
    logic [4:0] b;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  assign cnt_now  = gray_to_bin(dv_r.gray_s2);
  assign cnt_seen = cnt_now - dv_r.cnt_base;
  assign stb_rise = dv_r.stb_s2 & ~dv_r.stb_d;

  always_comb begin
    dv_nxt         = dv_r;
    dv_nxt.stb_s1  = link.strobe;
    dv_nxt.stb_s2  = dv_r.stb_s1;
    dv_nxt.stb_d   = dv_r.stb_s2;
    dv_nxt.gray_s1 = lk_r.cnt_gray;
    dv_nxt.gray_s2 = dv_r.gray_s1;
    dv_nxt.load    = 1'b0;
    if (stb_rise) begin
      // link clock is idle while the strobe is high, so the shift
      // word is quasi-static when the synchronised edge arrives
      dv_nxt.load     = 1'b1;
      dv_nxt.cnt_base = cnt_now;
      dv_nxt.mod_en   = 1'b1;
      if (cnt_seen >= `LDS_ALARM_MIN) begin
        dv_nxt.alarm = 1'b1;
        dv_nxt.code  = lk_r.shift;
        dv_nxt.level = lk_r.shift;
      end else begin
        dv_nxt.alarm = 1'b0;
        dv_nxt.code  = {1'b0, lk_r.shift[15:0]};
        // one normal step is one alarm step, offset by 4 mA
        dv_nxt.level = `LDS_ZERO_LEVEL + {1'b0, lk_r.shift[15:0]};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dv_r          <= '0;
      dv_r.cnt_base <= '0;
      // strobe idles high; starting the edge detector there avoids a false load
      dv_r.stb_s1   <= 1'b1;
      dv_r.stb_s2   <= 1'b1;
      dv_r.stb_d    <= 1'b1;
      dv_r.code     <= `LDS_CODE_RST;
    end else if (ce_in) begin
      dv_r <= dv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign code_out    = dv_r.code;
  assign alarm_out   = dv_r.alarm;
  assign level_out   = dv_r.level;
  assign mod_en_out  = dv_r.mod_en;
  assign osc_run_out = dv_r.mod_en;
  assign load_out    = dv_r.load;

endmodule : lds_dev

// ===== bench/lds_link_props.sv
// assertion checker for the link and the converter end
`timescale 1ns/100ps
module lds_link_props (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        sclk,
  input wire logic        sdata,
  input wire logic        strobe,
  input wire logic [16:0] code_out,
  input wire logic        alarm_out,
  input wire logic        mod_en_out,
  input wire logic        osc_run_out,
  input wire logic        load_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  property p_sclk_idle;
    strobe |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock active while strobe high");
  property p_sdata_stable;
    $rose(sclk) |-> $stable(sdata);
  endproperty
  a_sdata_stable: assert property (p_sdata_stable) else $error("data moved at clock rise");
  property p_strobe_quiet;
    $rose(strobe) |-> !$past(sclk) && !$past(sclk, 2) && !$past(sclk, 3);
  endproperty
  a_strobe_quiet: assert property (p_strobe_quiet) else $error("clock too close to strobe rise");
  property p_load_time;
    $rose(strobe) |-> ##[2:5] load_out;
  endproperty
  a_load_time: assert property (p_load_time) else $error("no load after strobe rise");
  property p_load_cause;
    load_out |-> strobe && $past(strobe, 2);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("load without strobe");
  // code and mode move only with a load, so the scale always matches
  property p_code_hold;
    $changed(code_out) |-> load_out || $past(load_out);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed without load");
  property p_alarm_hold;
    $changed(alarm_out) |-> load_out || $past(load_out);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("mode changed without load");
  property p_osc_follow;
    osc_run_out == mod_en_out;
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("oscillator and modulator disagree");
endmodule : lds_link_props

// ===== bench/lds_loader_test.sv
// bench: host and converter ends joined, plus a converter on a bench-driven link
`timescale 1ns/100ps
module loop_dac_serial_code_loader_test;
  import lds_pkg::*;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        start_r = 1'b0;
  logic        alarm_r = 1'b0;
  logic [16:0] word_r = 17'h00000;
  logic        ready_w, done_w;
  logic [16:0] code_w [2], level_w [2];
  logic        alarm_w [2], mod_en_w [2], osc_w [2], load_w [2];
  logic [47:0] pat = 48'h9a5c3e71b24d;
  int          n_errors = 0, n_checks = 0, n_loads = 0;
  lds_link_if link_a ();
  lds_link_if link_b ();
  lds_host i_lds_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .start_in(start_r),
    .alarm_in(alarm_r), .word_in(word_r), .link(link_a), .ready_out(ready_w), .done_out(done_w));
  lds_dev i_lds_dev (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .link(link_a),
    .code_out(code_w[0]), .alarm_out(alarm_w[0]), .level_out(level_w[0]), .mod_en_out(mod_en_w[0]),
    .osc_run_out(osc_w[0]), .load_out(load_w[0]));
  lds_dev i_lds_dev_b (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .link(link_b),
    .code_out(code_w[1]), .alarm_out(alarm_w[1]), .level_out(level_w[1]), .mod_en_out(mod_en_w[1]),
    .osc_run_out(osc_w[1]), .load_out(load_w[1]));
  lds_link_props i_lds_link_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk(link_a.sclk),
    .sdata(link_a.sdata), .strobe(link_a.strobe), .code_out(code_w[0]), .alarm_out(alarm_w[0]),
    .mod_en_out(mod_en_w[0]), .osc_run_out(osc_w[0]), .load_out(load_w[0]));
  always #20 clk_in = ~clk_in;
  always @(negedge clk_in) if (load_w[0] === 1'b1) n_loads++;
  // ----
  // compare tasks
  // ----
  task automatic chk_code(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_code
  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_code(what, {16'h0000, exp}, {16'h0000, got});
  endtask : chk_flag
  task automatic chk_out(input int d, input logic [16:0] c, input logic a);
    chk_code("code", c, code_w[d]);
    chk_flag("alarm", a, alarm_w[d]);
    chk_code("level", a ? c : c + 17'h04000, level_w[d]);
    chk_flag("mod_en", 1'b1, mod_en_w[d]);
  endtask : chk_out
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // ----
  // scenarios
  // ----
  task automatic host_send(input logic a, input logic [16:0] w);
    int n0, k;
    n0 = n_loads;
    @(posedge clk_in);
    start_r <= 1'b1;
    alarm_r <= a;
    word_r <= w;
    @(posedge clk_in);
    start_r <= 1'b0;
    for (k = 0; k < 400 && done_w !== 1'b1; k++) @(negedge clk_in);
    chk_flag("done", 1'b1, done_w);
    repeat (6) @(negedge clk_in);
    chk_code("loads", 17'h00001, 17'(n_loads - n0));
  endtask : host_send
  // bench-made link clock, only inside frames
  task automatic raw_send(input int n);
    link_b.strobe = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link_b.sdata = pat[i];
      #62.5 link_b.sclk = 1'b1;
      #62.5 link_b.sclk = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    link_b.strobe = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask : raw_send
  task automatic t_reset();
    @(negedge clk_in);
    chk_flag("ready", 1'b1, ready_w);
    for (int d = 0; d < 2; d++) begin
      chk_code("code", 17'h00000, code_w[d]);
      chk_flag("mod_en", 1'b0, mod_en_w[d]);
      chk_flag("osc", 1'b0, osc_w[d]);
    end
  endtask : t_reset
  task automatic t_normal();
    logic [15:0] ws [6] = '{16'h0000, 16'h4000, 16'h8000, 16'hc000, 16'hffff, 16'ha5c3};
    foreach (ws[j]) begin
      host_send(1'b0, {1'b0, ws[j]});
      chk_out(0, {1'b0, ws[j]}, 1'b0);
    end
  endtask : t_normal
  task automatic t_alarm();
    logic [16:0] ws [4] = '{17'h03800, 17'h03c00, 17'h14000, 17'h18000};
    foreach (ws[j]) begin
      host_send(1'b1, ws[j]);
      chk_out(0, ws[j], 1'b1);
    end
    host_send(1'b0, 17'h00001);
    chk_out(0, 17'h00001, 1'b0);
  endtask : t_alarm
  task automatic t_counts();
    int   ns [6] = '{17, 31, 32, 48, 0, 33};
    logic al;
    foreach (ns[j]) begin
      raw_send(ns[j]);
      al = (ns[j] % 32) >= 17;
      chk_out(1, al ? pat[16:0] : {1'b0, pat[15:0]}, al);
    end
  endtask : t_counts
  initial begin
    #800000;
    n_errors++;
    results();
  end
  initial begin
    link_b.sclk = 1'b0;
    link_b.sdata = 1'b0;
    link_b.strobe = 1'b1;
    // link side resets asynchronously; clock edges during reset change nothing
    fork
      repeat (3) begin
        #20 link_b.sclk = 1'b1;
        #20 link_b.sclk = 1'b0;
      end
      repeat (4) @(posedge clk_in);
    join
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_normal();
    t_alarm();
    t_counts();
    results();
  end
endmodule : loop_dac_serial_code_loader_test
